// [common/pfctrm_pkg.sv]
// Package with register map, field layout and carrier types for the trim and sticky flag bank.
package pfctrm_pkg;
    localparam logic [15:0] ADDR_UV_HYS = 16'hFE51;
    localparam logic [15:0] ADDR_LINE_OFS = 16'hFE53;
    localparam logic [15:0] ADDR_CS_LO_OFS = 16'hFE54;
    localparam logic [15:0] ADDR_CS_HI_GAIN = 16'hFE7E;
    localparam logic [15:0] ADDR_CS_HI_OFS = 16'hFE7F;
    localparam logic [15:0] ADDR_FLAGS0 = 16'hFE80;
    localparam logic [15:0] ADDR_FLAGS1 = 16'hFE81;
    localparam logic [15:0] ADDR_FLAGS2 = 16'hFE82;
    localparam logic [7:0] TRIM_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] FLAGS1_MASK = 8'h7F;
    localparam logic [7:0] FLAGS2_MASK = 8'h3E;
    localparam int RESP_MSB = 7;
    localparam int RESP_LSB = 6;
    localparam logic [1:0] RESP_DISABLE = 2'h2;
    localparam int GAIN_SIGN_BIT = 7;
    localparam int FLAG_REGS = 3;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } pfctrm_req_t;

    typedef struct packed {
        logic max_modulation;
        logic min_modulation;
        logic divider_fault;
        logic quick_overvoltage_trip;
        logic line_period_missing;
        logic line_sag;
        logic soft_start;
        logic relay_off;
    } pfctrm_cond0_t;

    typedef struct packed {
        logic rsvd;
        logic eeprom_unlocked;
        logic eeprom_bad;
        logic address_marginal;
        logic high_line;
        logic quick_overcurrent_trip;
        logic sync_locked;
        logic line_good_low;
    } pfctrm_cond1_t;

    typedef struct packed {
        logic [1:0] rsvd_hi;
        logic low_power;
        logic fast_loop;
        logic core_rail_over;
        logic supply_rail_over;
        logic supply_rail_under;
        logic rsvd_lo;
    } pfctrm_cond2_t;
endpackage : pfctrm_pkg

// [verilog/pfctrm_bank.sv]
// Trim registers, undervoltage restart hysteresis and read-to-clear sticky flag registers.
`timescale 1ns/1ps
`default_nettype none
module pfctrm_bank #(
    parameter int ADC_W = 12,
    parameter int VIN_W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire pfctrm_pkg::pfctrm_req_t req,
    output logic [7:0] rdata,
    input wire logic trim_unlock,
    input wire logic [1:0] input_undervoltage_response,
    input wire logic [VIN_W-1:0] input_undervoltage_limit,
    input wire logic [VIN_W-1:0] input_turn_on_threshold,
    input wire logic [VIN_W-1:0] line_voltage_input,
    input wire logic uv_fault,
    output logic output_enable,
    input wire logic [ADC_W-1:0] line_adc_raw,
    output logic [ADC_W-1:0] line_adc_trimmed,
    input wire logic [ADC_W-1:0] cs_adc_raw,
    input wire logic cs_high_range,
    output logic [ADC_W-1:0] cs_adc_trimmed,
    output logic gain_negative,
    output logic [6:0] gain_magnitude,
    input wire pfctrm_pkg::pfctrm_cond0_t cond0,
    input wire pfctrm_pkg::pfctrm_cond1_t cond1,
    input wire pfctrm_pkg::pfctrm_cond2_t cond2
);
    import pfctrm_pkg::*;

    logic [7:0] uv_hys_r;
    logic [7:0] line_ofs_r;
    logic [7:0] cs_lo_ofs_r;
    logic [7:0] cs_hi_gain_r;
    logic [7:0] cs_hi_ofs_r;
    logic [7:0] flags_r [FLAG_REGS];
    logic [7:0] set_vec [FLAG_REGS];
    logic [7:0] mask_vec [FLAG_REGS];
    logic uv_tripped_r;
    logic [VIN_W:0] restart_level;
    logic hys_active;
    logic trim_wr;

    // Saturating subtraction so a large offset never wraps a small reading to full scale.
    function automatic logic [ADC_W-1:0] sub_sat(input logic [ADC_W-1:0] a, input logic [7:0] b);
        logic [ADC_W-1:0] bw;
        bw = ADC_W'(b);
        sub_sat = (a > bw) ? a - bw : '0;
    endfunction : sub_sat

    function automatic int flag_index(input logic [15:0] a);
        case (a)
            ADDR_FLAGS0: flag_index = 0;
            ADDR_FLAGS1: flag_index = 1;
            ADDR_FLAGS2: flag_index = 2;
            default: flag_index = -1;
        endcase
    endfunction : flag_index

    ////////////////////////////////////////////////////////////////////////////
    assign trim_wr = req.wr && trim_unlock;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            uv_hys_r <= TRIM_RESET;
        end else if (req.wr && req.addr == ADDR_UV_HYS) begin
            uv_hys_r <= req.wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_ofs_r <= TRIM_RESET;
            cs_lo_ofs_r <= TRIM_RESET;
            cs_hi_gain_r <= TRIM_RESET;
            cs_hi_ofs_r <= TRIM_RESET;
        end else if (trim_wr) begin
            case (req.addr)
                ADDR_LINE_OFS: line_ofs_r <= req.wdata;
                ADDR_CS_LO_OFS: cs_lo_ofs_r <= req.wdata;
                ADDR_CS_HI_GAIN: cs_hi_gain_r <= req.wdata;
                ADDR_CS_HI_OFS: cs_hi_ofs_r <= req.wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output disable on undervoltage; the fault detector itself lives outside.
    assign hys_active = input_undervoltage_response == RESP_DISABLE;
    assign restart_level = hys_active ? {1'b0, input_undervoltage_limit} + (VIN_W+1)'(uv_hys_r)
                                      : {1'b0, input_undervoltage_limit};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            uv_tripped_r <= 1'b0;
        end else if (uv_fault && hys_active) begin
            uv_tripped_r <= 1'b1;
        end else if ({1'b0, line_voltage_input} > restart_level) begin
            uv_tripped_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_enable <= 1'b0;
        end else begin
            output_enable <= !uv_tripped_r && !(uv_fault && hys_active);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_adc_trimmed <= '0;
            cs_adc_trimmed <= '0;
            gain_negative <= 1'b0;
            gain_magnitude <= '0;
        end else begin
            line_adc_trimmed <= sub_sat(line_adc_raw, line_ofs_r);
            cs_adc_trimmed <= sub_sat(cs_adc_raw, cs_high_range ? cs_hi_ofs_r : cs_lo_ofs_r);
            gain_negative <= cs_hi_gain_r[GAIN_SIGN_BIT];
            gain_magnitude <= cs_hi_gain_r[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Condition inputs are on-chip logic on this clock, so no synchroniser.
    assign set_vec[0] = cond0;
    assign set_vec[1] = cond1 & FLAGS1_MASK;
    assign set_vec[2] = cond2 & FLAGS2_MASK;
    assign mask_vec[0] = 8'hFF;
    assign mask_vec[1] = FLAGS1_MASK;
    assign mask_vec[2] = FLAGS2_MASK;

    for (genvar g = 0; g < FLAG_REGS; g++) begin : g_flags
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                flags_r[g] <= FLAGS_RESET;
            end else if (req.rd && flag_index(req.addr) == g) begin
                flags_r[g] <= set_vec[g];
            end else begin
                flags_r[g] <= flags_r[g] | set_vec[g];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                ADDR_UV_HYS: rdata <= uv_hys_r;
                ADDR_LINE_OFS: rdata <= line_ofs_r;
                ADDR_CS_LO_OFS: rdata <= cs_lo_ofs_r;
                ADDR_CS_HI_GAIN: rdata <= cs_hi_gain_r;
                ADDR_CS_HI_OFS: rdata <= cs_hi_ofs_r;
                ADDR_FLAGS0: rdata <= flags_r[0];
                ADDR_FLAGS1: rdata <= flags_r[1] & mask_vec[1];
                ADDR_FLAGS2: rdata <= flags_r[2] & mask_vec[2];
                default: rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    trim_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.wr && !trim_unlock && req.addr == ADDR_LINE_OFS) |=> $stable(line_ofs_r))
        else $error("Line offset trim changed while locked.");

    trim_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.wr && trim_unlock && req.addr == ADDR_CS_HI_OFS) |=> cs_hi_ofs_r == $past(req.wdata))
        else $error("Unlocked trim write not stored.");

    line_trim_a: assert property (@(posedge clk) disable iff (!rst_n)
        (line_adc_raw > ADC_W'(line_ofs_r)) |=> line_adc_trimmed == $past(line_adc_raw) - ADC_W'($past(line_ofs_r)))
        else $error("Line reading not offset corrected.");

    cs_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cs_high_range && cs_adc_raw > ADC_W'(cs_hi_ofs_r))
        |=> cs_adc_trimmed == $past(cs_adc_raw) - ADC_W'($past(cs_hi_ofs_r)))
        else $error("High range offset not applied.");

    gain_sign_a: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> gain_negative == $past(cs_hi_gain_r[GAIN_SIGN_BIT]))
        else $error("Gain sign not from bit seven.");

    flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (flags_r[0][3] && !(req.rd && req.addr == ADDR_FLAGS0)) |=> flags_r[0][3])
        else $error("Sticky flag dropped without read.");

    flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == ADDR_FLAGS1 && set_vec[1] == 8'h00 && set_vec[0] == 8'h00)
        |=> flags_r[1] == 8'h00 && flags_r[0] == $past(flags_r[0]))
        else $error("Read clear hit the wrong register.");

    flag_race_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == ADDR_FLAGS2 && cond2.core_rail_over) |=> flags_r[2][3])
        else $error("Event lost during read clear.");

    rsvd_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == ADDR_FLAGS2) |=> rdata[7:6] == 2'h0 && rdata[0] == 1'b0)
        else $error("Reserved flag bits not zero.");

    uv_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
        (uv_tripped_r && {1'b0, line_voltage_input} <= restart_level && !uv_fault) |=> ##1 !output_enable)
        else $error("Output restarted below hysteresis level.");

    uv_trip_a: assert property (@(posedge clk) disable iff (!rst_n)
        (uv_fault && hys_active) |=> !output_enable)
        else $error("Output kept running through undervoltage.");

    uv_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        (uv_tripped_r && !uv_fault && {1'b0, line_voltage_input} > restart_level) |=> !uv_tripped_r)
        else $error("Trip not released above hysteresis level.");

    hys_ignored_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!hys_active && !uv_tripped_r) |=> output_enable)
        else $error("Other response disabled the output.");

    hys_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.wr && req.addr == ADDR_UV_HYS) |=> uv_hys_r == $past(req.wdata))
        else $error("Hysteresis write not stored.");

    lo_ofs_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.wr && !trim_unlock && req.addr == ADDR_CS_LO_OFS) |=> $stable(cs_lo_ofs_r))
        else $error("Low range offset changed while locked.");

    gain_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.wr && !trim_unlock && req.addr == ADDR_CS_HI_GAIN) |=> $stable(cs_hi_gain_r))
        else $error("Gain trim changed while locked.");

    hi_ofs_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.wr && !trim_unlock && req.addr == ADDR_CS_HI_OFS) |=> $stable(cs_hi_ofs_r))
        else $error("High range offset changed while locked.");

    line_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.wr && trim_unlock && req.addr == ADDR_LINE_OFS) |=> line_ofs_r == $past(req.wdata))
        else $error("Unlocked line offset write not stored.");

    lo_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.wr && trim_unlock && req.addr == ADDR_CS_LO_OFS) |=> cs_lo_ofs_r == $past(req.wdata))
        else $error("Unlocked low range write not stored.");

    gain_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.wr && trim_unlock && req.addr == ADDR_CS_HI_GAIN) |=> cs_hi_gain_r == $past(req.wdata))
        else $error("Unlocked gain write not stored.");

    line_floor_a: assert property (@(posedge clk) disable iff (!rst_n)
        (line_adc_raw <= ADC_W'(line_ofs_r)) |=> line_adc_trimmed == '0)
        else $error("Line reading not floored at zero.");

    cs_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!cs_high_range && cs_adc_raw > ADC_W'(cs_lo_ofs_r))
        |=> cs_adc_trimmed == $past(cs_adc_raw) - ADC_W'($past(cs_lo_ofs_r)))
        else $error("Low range offset not applied.");

    gain_mag_a: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> gain_magnitude == $past(cs_hi_gain_r[6:0]))
        else $error("Gain magnitude not from low seven bits.");

    // Every condition bit outside the masked reserved bits is latched one edge after it is seen, even during a read-clear.
    max_mod_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond0.max_modulation |=> flags_r[0][7])
        else $error("Maximum modulation flag not latched.");

    min_mod_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond0.min_modulation |=> flags_r[0][6])
        else $error("Minimum modulation flag not latched.");

    divider_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond0.divider_fault |=> flags_r[0][5])
        else $error("Divider fault flag not latched.");

    quick_ov_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond0.quick_overvoltage_trip |=> flags_r[0][4])
        else $error("Quick overvoltage flag not latched.");

    period_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond0.line_period_missing |=> flags_r[0][3])
        else $error("Missing period flag not latched.");

    sag_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond0.line_sag |=> flags_r[0][2])
        else $error("Line sag flag not latched.");

    soft_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond0.soft_start |=> flags_r[0][1])
        else $error("Soft start flag not latched.");

    relay_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond0.relay_off |=> flags_r[0][0])
        else $error("Relay off flag not latched.");

    eeprom_open_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond1.eeprom_unlocked |=> flags_r[1][6])
        else $error("EEPROM unlocked flag not latched.");

    eeprom_bad_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond1.eeprom_bad |=> flags_r[1][5])
        else $error("EEPROM check flag not latched.");

    addr_margin_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond1.address_marginal |=> flags_r[1][4])
        else $error("Address margin flag not latched.");

    high_line_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond1.high_line |=> flags_r[1][3])
        else $error("High line flag not latched.");

    quick_oc_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond1.quick_overcurrent_trip |=> flags_r[1][2])
        else $error("Quick overcurrent flag not latched.");

    sync_locked_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond1.sync_locked |=> flags_r[1][1])
        else $error("Sync locked flag not latched.");

    line_good_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond1.line_good_low |=> flags_r[1][0])
        else $error("Line good flag not latched.");

    low_power_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond2.low_power |=> flags_r[2][5])
        else $error("Low power flag not latched.");

    fast_loop_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond2.fast_loop |=> flags_r[2][4])
        else $error("Fast loop flag not latched.");

    core_over_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond2.core_rail_over |=> flags_r[2][3])
        else $error("Core rail flag not latched.");

    supply_over_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond2.supply_rail_over |=> flags_r[2][2])
        else $error("Supply overvoltage flag not latched.");

    supply_under_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond2.supply_rail_under |=> flags_r[2][1])
        else $error("Supply undervoltage flag not latched.");

    hold_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(req.rd && req.addr == ADDR_FLAGS0) |=> (flags_r[0] & $past(flags_r[0])) == $past(flags_r[0]))
        else $error("First flag register dropped a bit.");

    hold_second_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(req.rd && req.addr == ADDR_FLAGS1) |=> (flags_r[1] & $past(flags_r[1])) == $past(flags_r[1]))
        else $error("Second flag register dropped a bit.");

    hold_third_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(req.rd && req.addr == ADDR_FLAGS2) |=> (flags_r[2] & $past(flags_r[2])) == $past(flags_r[2]))
        else $error("Third flag register dropped a bit.");

    clear_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == ADDR_FLAGS0) |=> flags_r[0] == $past(set_vec[0]))
        else $error("First flag register not cleared by read.");

    clear_third_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == ADDR_FLAGS2) |=> flags_r[2] == $past(set_vec[2]))
        else $error("Third flag register not cleared by read.");

    read_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == ADDR_FLAGS0) |=> rdata == $past(flags_r[0]))
        else $error("First flag read lost its value.");

    read_second_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == ADDR_FLAGS1) |=> rdata == ($past(flags_r[1]) & FLAGS1_MASK))
        else $error("Second flag read lost its value.");

    read_third_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == ADDR_FLAGS2) |=> rdata == ($past(flags_r[2]) & FLAGS2_MASK))
        else $error("Third flag read lost its value.");

    rsvd_second_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == ADDR_FLAGS1) |=> rdata[7] == 1'b0)
        else $error("Reserved second flag bit not zero.");

    flag_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (req.wr && !req.rd && req.addr == ADDR_FLAGS0 && set_vec[0] == 8'h00) |=> flags_r[0] == $past(flags_r[0]))
        else $error("Write changed a flag register.");
endmodule : pfctrm_bank
`default_nettype wire

// [verification/pfctrm_host.sv]
// Host microcontroller model that issues register requests and owns the trim unlock.
`timescale 1ns/1ps
`default_nettype none
module pfctrm_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output pfctrm_pkg::pfctrm_req_t req,
    output logic trim_unlock
);
    import pfctrm_pkg::*;
    initial begin
        req = '0;
        trim_unlock = 1'b0;
    end
    // Trim values are only written after unlocking, except where a refusal is wanted.
    task automatic set_unlock(input logic on);
        trim_unlock = on;
    endtask : set_unlock
    // The request holds through the taking edge; a released bus drops both strobes and shows the inverse address and data.
    task automatic access(input logic wr, input logic [15:0] addr, input logic [7:0] wdata, output logic [7:0] data);
        @(posedge clk);
        #1;
        req = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
        @(posedge clk);
        #1;
        data = rdata;
        req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
    endtask : access
endmodule : pfctrm_host
`default_nettype wire

// [verification/pfctrm_bank_tb.sv]
// Self-checking bench for the trim registers, restart hysteresis and sticky flag registers.
`timescale 1ns/1ps
`default_nettype none
module pfctrm_bank_tb;
    import pfctrm_pkg::*;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic unlock;
        logic [7:0] exp;
    } pfctrm_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    pfctrm_req_t req;
    logic [7:0] rdata;
    logic trim_unlock;
    logic [1:0] uv_resp = 2'h2;
    logic [11:0] vin = 12'h200;
    logic uv_fault = 1'b0;
    logic oe;
    logic [11:0] line_raw = '0;
    logic [11:0] line_trim;
    logic [11:0] cs_raw = '0;
    logic cs_hi = 1'b0;
    logic [11:0] cs_trim;
    logic gain_neg;
    logic [6:0] gain_mag;
    logic [7:0] c0 = '0;
    logic [7:0] c1 = '0;
    logic [7:0] c2 = '0;
    logic [7:0] d;
    int fail_count = 0;
    int n_tests = 0;
    logic [7:0] msk [3] = '{8'hFF, FLAGS1_MASK, FLAGS2_MASK};
    pfctrm_row_t rows [9] = '{'{ADDR_UV_HYS, 8'h15, 1'b0, 8'h15}, '{ADDR_LINE_OFS, 8'hA5, 1'b0, 8'h00},
        '{ADDR_LINE_OFS, 8'h10, 1'b1, 8'h10}, '{ADDR_CS_LO_OFS, 8'h20, 1'b1, 8'h20},
        '{ADDR_CS_HI_GAIN, 8'h85, 1'b1, 8'h85}, '{ADDR_CS_HI_OFS, 8'h30, 1'b1, 8'h30},
        '{ADDR_CS_HI_OFS, 8'h55, 1'b0, 8'h30}, '{ADDR_FLAGS0, 8'hFF, 1'b1, 8'h00}, '{16'hFE52, 8'h7E, 1'b1, 8'h00}};

    always #5 clk = ~clk;

    pfctrm_host i_pfctrm_host (.clk(clk), .rdata(rdata), .req(req), .trim_unlock(trim_unlock));
    pfctrm_bank i_pfctrm_bank (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .trim_unlock(trim_unlock),
        .input_undervoltage_response(uv_resp), .input_undervoltage_limit(12'h100),
        .input_turn_on_threshold(12'h080), .line_voltage_input(vin), .uv_fault(uv_fault),
        .output_enable(oe), .line_adc_raw(line_raw), .line_adc_trimmed(line_trim), .cs_adc_raw(cs_raw),
        .cs_high_range(cs_hi), .cs_adc_trimmed(cs_trim), .gain_negative(gain_neg), .gain_magnitude(gain_mag),
        .cond0(pfctrm_cond0_t'(c0)), .cond1(pfctrm_cond1_t'(c1)), .cond2(pfctrm_cond2_t'(c2)));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        logic [7:0] x;
        i_pfctrm_host.access(1'b1, a, v, x);
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        i_pfctrm_host.access(1'b0, a, 8'h00, v);
    endtask : rd
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        tick(2);
        check("oe_after_reset", 12'(oe), 12'h001);
        for (int i = 0; i < 9; i++) begin
            i_pfctrm_host.set_unlock(rows[i].unlock);
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, d);
            check("reg_readback", 12'(d), 12'(rows[i].exp));
        end
        line_raw = 12'h005;
        cs_raw = 12'h100;
        tick(2);
        check("line_floor", line_trim, 12'h000);
        check("cs_low_range", cs_trim, 12'h0E0);
        check("gain_sign", 12'(gain_neg), 12'h001);
        check("gain_mag", 12'(gain_mag), 12'h005);
        line_raw = 12'h100;
        cs_hi = 1'b1;
        tick(2);
        check("line_trim", line_trim, 12'h0F0);
        check("cs_high_range", cs_trim, 12'h0D0);
        // One-cycle pulses, read two cycles later, prove that each unmasked bit holds after its cause goes away.
        for (int r = 0; r < 3; r++) begin
            for (int b = 0; b < 8; b++) begin
                {c2, c1, c0} = 24'h000001 << (r * 8 + b);
                tick(1);
                {c2, c1, c0} = '0;
                tick(2);
                rd(16'(ADDR_FLAGS0 + r), d);
                check("flag_bit", 12'(d), 12'((8'h01 << b) & msk[r]));
            end
        end
        {c2, c1, c0} = 24'hFFFFFF;
        tick(1);
        {c2, c1, c0} = '0;
        rd(ADDR_FLAGS1, d);
        check("flags1_all", 12'(d), 12'h07F);
        rd(ADDR_FLAGS1, d);
        check("flags1_cleared", 12'(d), 12'h000);
        wr(ADDR_FLAGS0, 8'h00);
        rd(ADDR_FLAGS0, d);
        check("flags0_kept", 12'(d), 12'h0FF);
        rd(ADDR_FLAGS2, d);
        check("flags2_kept", 12'(d), 12'h03E);
        c0 = 8'h80;
        rd(ADDR_FLAGS0, d);
        rd(ADDR_FLAGS0, d);
        check("active_during_clear", 12'(d), 12'h080);
        c0 = 8'h00;
        rd(ADDR_FLAGS0, d);
        check("kept_after_clear", 12'(d), 12'h080);
        rd(ADDR_FLAGS0, d);
        check("cleared_at_last", 12'(d), 12'h000);
        uv_fault = 1'b1;
        vin = 12'h0F0;
        tick(2);
        check("uv_trip", 12'(oe), 12'h000);
        uv_fault = 1'b0;
        vin = 12'h115;
        tick(3);
        check("uv_at_limit_plus_hys", 12'(oe), 12'h000);
        vin = 12'h116;
        tick(3);
        check("uv_above_hys", 12'(oe), 12'h001);
        uv_resp = 2'h1;
        uv_fault = 1'b1;
        vin = 12'h0F0;
        tick(3);
        check("uv_other_response", 12'(oe), 12'h001);
        conclude();
    end

    // The sequence takes well under ten microseconds; this limit only catches a hang.
    initial begin
        #100000;
        fail_count++;
        conclude();
    end
endmodule : pfctrm_bank_tb
`default_nettype wire
